// ### hdl/asg_pkg.sv
// Shared constants and types of the arbitrary sequence generator
package asg_pkg;
   localparam logic [15:0] ADDR_GLIM_VOLT = 16'h01F4;
   localparam logic [15:0] ADDR_GLIM_CURR = 16'h01F5;
   localparam logic [15:0] ADDR_GLIM_PWR = 16'h01F6;
   localparam logic [15:0] ADDR_RUN_COIL = 16'h0352;
   localparam logic [15:0] ADDR_VSEL_COIL = 16'h0353;
   localparam logic [15:0] ADDR_CSEL_COIL = 16'h0354;
   localparam logic [15:0] ADDR_FIRST_PT = 16'h035B;
   localparam logic [15:0] ADDR_LAST_PT = 16'h035C;
   localparam logic [15:0] ADDR_CYCLES = 16'h035D;
   localparam logic [15:0] ADDR_TABLE = 16'h0384;
   localparam int POINTS = 99;
   localparam int VALS_PER_POINT = 8;
   localparam logic [15:0] REGS_PER_POINT = 16'h0010;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;
   localparam logic [15:0] COIL_READ_ON = 16'h0001;
   localparam logic [15:0] LIMIT_FULL_SCALE = 16'hCCCC;
   localparam logic [15:0] CYCLES_INFINITE = 16'h0000;
   localparam logic [15:0] CYCLES_RESET = 16'h0001;
   localparam logic [2:0] IDX_DURATION = 3'h7;
   localparam logic [2:0] IDX_ANGLE = 3'h4;
   localparam logic [7:0] FP_EXP_ONES = 8'hFF;
   localparam logic [7:0] FP_EXP_BIAS = 8'h7F;
   localparam logic [7:0] FP_EXP_MAX = 8'h9E;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_NS = 1000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ASG_OP_READ, ASG_OP_WR_SINGLE, ASG_OP_WR_MULTI, ASG_OP_WR_COIL} asg_op_t;
   typedef struct packed {
      logic valid;
      asg_op_t op;
      logic [15:0] addr;
      logic [15:0] data;
   } asg_req_t;
   typedef struct packed {
      logic valid;
      logic exc;
      logic [15:0] data;
   } asg_rsp_t;
   typedef struct packed {
      logic [31:0] volt;
      logic [31:0] curr;
   } asg_adj_t;
   typedef struct packed {
      logic [15:0] volt;
      logic [15:0] curr;
      logic [15:0] pwr;
   } asg_glim_t;
   typedef logic [VALS_PER_POINT-1:0][31:0] asg_point_t;
endpackage

// ### hdl/asg_tick_div.sv
// Microsecond enable divider
`timescale 1ns/1ns
`default_nettype none
module asg_tick_div #(
   parameter int DIV = asg_pkg::TICK_CYCLES
) (
   input wire logic core_clk_i, // System clock
   input wire logic reset_i,    // Sync reset
   input wire logic en_i,       // Restarts phase when low
   output logic tick_o          // One-cycle enable
);
   initial if (DIV < 2) $error("asg_tick_div: DIV below 2");
   logic [$clog2(DIV)-1:0] cnt_ff;

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i || !en_i)
      begin
         cnt_ff <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= (cnt_ff == $bits(cnt_ff)'(DIV - 1));
         if (cnt_ff == $bits(cnt_ff)'(DIV - 1))
            cnt_ff <= '0;
         else
            cnt_ff <= cnt_ff + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### hdl/asg_val_check.sv
// Validation of one sequence point value against adjustment limits
`timescale 1ns/1ns
`default_nettype none
module asg_val_check (
   input wire logic [2:0] idx_i,          // Value index in point
   input wire logic [31:0] value_i,       // Float value
   input wire logic tgt_volt_i,           // Voltage is target
   input wire asg_pkg::asg_adj_t adj_i,   // Adjustment limits
   output logic ok_o                      // Value accepted
);
   logic [31:0] lim;
   logic is_nan;
   logic neg;

   always_comb
   begin
      lim = tgt_volt_i ? adj_i.volt : adj_i.curr;
      is_nan = (value_i[30:23] == asg_pkg::FP_EXP_ONES);
      neg = value_i[31] && (value_i[30:0] != '0);
      // Positive floats order like their bit patterns
      case (idx_i)
         asg_pkg::IDX_ANGLE: ok_o = !is_nan;
         3'h2, 3'h3, asg_pkg::IDX_DURATION: ok_o = !is_nan && !neg;
         default: ok_o = !is_nan && !neg && (value_i[30:0] <= lim[30:0]);
      endcase
   end
endmodule
`default_nettype wire

// ### hdl/asg_ctrl.sv
// Register-controlled arbitrary sequence generator
`timescale 1ns/1ns
`default_nettype none
module asg_ctrl #(
   parameter int POINTS = asg_pkg::POINTS,
   parameter int TICK_DIV = asg_pkg::TICK_CYCLES
) (
   input wire logic core_clk_i,            // 100 MHz clock
   input wire logic reset_i,               // Sync reset
   input wire asg_pkg::asg_req_t req_i,    // Decoded host access
   output asg_pkg::asg_rsp_t rsp_o,        // Access answer
   input wire asg_pkg::asg_adj_t adj_i,    // Adjustment limits
   input wire logic dc_on_i,               // Terminals on
   output asg_pkg::asg_point_t point_o,    // Values of running point
   output logic point_strobe_o,            // New point loaded
   output logic gen_active_o,              // Generator drives setpoint
   output logic static_mode_o,             // Static values regulate
   output logic tgt_volt_o,                // Voltage target selected
   output logic tgt_curr_o,                // Current target selected
   output asg_pkg::asg_glim_t glim_o,      // Global limits
   output logic dc_on_req_o,               // Pulse: switch terminals on
   output logic run_done_o                 // Pulse: finite run ended
);
   initial if (POINTS < 1 || POINTS > 127) $error("asg_ctrl: POINTS out of range");
   localparam int MEM_WORDS = POINTS * asg_pkg::VALS_PER_POINT;
   localparam logic [15:0] TABLE_END = asg_pkg::ADDR_TABLE + 16'(POINTS * 16);
   localparam logic [15:0] POINTS_W = 16'(POINTS);

   typedef enum {SQ_IDLE, SQ_LOAD, SQ_RUN} asg_seq_t;
   asg_seq_t state_ff;

   logic [31:0] mem [MEM_WORDS];
   logic [POINTS-1:0] loaded_ff;
   logic [15:0] first_ff;
   logic [15:0] last_ff;
   logic [15:0] cycles_ff;
   logic [15:0] hi_ff;
   logic [15:0] hi_addr_ff;
   logic hi_vld_ff;
   logic [6:0] cur_pt_ff;
   logic [15:0] cyc_left_ff;
   logic [31:0] rem_us_ff;
   logic tick;

   // Access decode
   logic is_wr;
   logic is_tbl;
   logic [15:0] off;
   logic [6:0] pt;
   logic [2:0] wd;
   logic sel_any;
   logic val_ok;
   logic acc_ok;
   logic do_start;
   logic do_stop;
   logic do_exit;
   logic tbl_hi;
   logic tbl_commit;
   logic idx_ok;

   always_comb
   begin
      is_wr = req_i.op == asg_pkg::ASG_OP_WR_SINGLE || req_i.op == asg_pkg::ASG_OP_WR_MULTI;
      is_tbl = req_i.addr >= asg_pkg::ADDR_TABLE && req_i.addr < TABLE_END;
      off = req_i.addr - asg_pkg::ADDR_TABLE;
      pt = off[10:4];
      wd = off[3:1];
      sel_any = tgt_volt_o || tgt_curr_o;
      idx_ok = first_ff != '0 && first_ff <= last_ff && last_ff <= POINTS_W;
      acc_ok = 1'b0;
      do_start = 1'b0;
      do_stop = 1'b0;
      do_exit = 1'b0;
      tbl_hi = 1'b0;
      tbl_commit = 1'b0;
      if (req_i.valid)
      begin
         if (req_i.op == asg_pkg::ASG_OP_WR_COIL)
         begin
            case (req_i.addr)
               asg_pkg::ADDR_RUN_COIL:
               begin
                  do_start = req_i.data == asg_pkg::COIL_ON && sel_any && idx_ok;
                  do_stop = req_i.data == asg_pkg::COIL_OFF;
                  acc_ok = do_start || do_stop;
               end
               asg_pkg::ADDR_VSEL_COIL, asg_pkg::ADDR_CSEL_COIL:
               begin
                  do_exit = req_i.data == asg_pkg::COIL_OFF && sel_any;
                  acc_ok = do_exit || (req_i.data == asg_pkg::COIL_ON && !sel_any);
               end
               default: acc_ok = 1'b0;
            endcase
         end
         else if (is_wr && is_tbl)
         begin
            // Upper half first; lower half commits the checked float
            tbl_hi = sel_any && !off[0];
            tbl_commit = sel_any && off[0] && hi_vld_ff && val_ok &&
               hi_addr_ff == req_i.addr - 16'h0001;
            acc_ok = tbl_hi || tbl_commit;
         end
         else if (is_wr)
         begin
            case (req_i.addr)
               asg_pkg::ADDR_GLIM_VOLT, asg_pkg::ADDR_GLIM_CURR, asg_pkg::ADDR_GLIM_PWR,
               asg_pkg::ADDR_FIRST_PT, asg_pkg::ADDR_LAST_PT, asg_pkg::ADDR_CYCLES:
                  acc_ok = 1'b1;
               default: acc_ok = 1'b0;
            endcase
         end
         else
            acc_ok = req_i.op == asg_pkg::ASG_OP_READ;
      end
   end

   asg_val_check u_check (
      .idx_i(wd),
      .value_i({hi_ff, req_i.data}),
      .tgt_volt_i(tgt_volt_o),
      .adj_i(adj_i),
      .ok_o(val_ok)
   );

   // Configuration registers; exit wipes them so nothing outlives a use
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i || do_exit)
      begin
         tgt_volt_o <= 1'b0;
         tgt_curr_o <= 1'b0;
         first_ff <= '0;
         last_ff <= '0;
         cycles_ff <= asg_pkg::CYCLES_RESET;
         glim_o <= {3{asg_pkg::LIMIT_FULL_SCALE}};
      end
      else if (req_i.valid && acc_ok)
      begin
         if (req_i.op == asg_pkg::ASG_OP_WR_COIL && req_i.data == asg_pkg::COIL_ON)
         begin
            if (req_i.addr == asg_pkg::ADDR_VSEL_COIL)
               tgt_volt_o <= 1'b1;
            if (req_i.addr == asg_pkg::ADDR_CSEL_COIL)
               tgt_curr_o <= 1'b1;
         end
         if (is_wr)
         begin
            case (req_i.addr)
               asg_pkg::ADDR_GLIM_VOLT: glim_o.volt <= req_i.data;
               asg_pkg::ADDR_GLIM_CURR: glim_o.curr <= req_i.data;
               asg_pkg::ADDR_GLIM_PWR: glim_o.pwr <= req_i.data;
               asg_pkg::ADDR_FIRST_PT: first_ff <= req_i.data;
               asg_pkg::ADDR_LAST_PT: last_ff <= req_i.data;
               asg_pkg::ADDR_CYCLES: cycles_ff <= req_i.data;
               default: first_ff <= first_ff;
            endcase
         end
      end
   end

   // Sequence table; loaded flags stand in for clearing the array
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i || do_exit)
      begin
         loaded_ff <= '0;
         hi_vld_ff <= 1'b0;
         hi_ff <= '0;
         hi_addr_ff <= '0;
      end
      else if (tbl_hi)
      begin
         hi_ff <= req_i.data;
         hi_addr_ff <= req_i.addr;
         hi_vld_ff <= 1'b1;
      end
      else if (tbl_commit)
      begin
         mem[{pt, wd}] <= {hi_ff, req_i.data};
         loaded_ff[pt] <= 1'b1;
         hi_vld_ff <= 1'b0;
      end
   end

   // Access answer, one cycle after the request
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
         rsp_o <= '0;
      else
      begin
         rsp_o.valid <= req_i.valid;
         rsp_o.exc <= req_i.valid && !acc_ok;
         rsp_o.data <= '0;
         if (req_i.valid && req_i.op == asg_pkg::ASG_OP_READ)
         begin
            if (is_tbl)
            begin
               if (loaded_ff[pt])
                  rsp_o.data <= off[0] ? mem[{pt, wd}][15:0] : mem[{pt, wd}][31:16];
            end
            else
            begin
               case (req_i.addr)
                  asg_pkg::ADDR_GLIM_VOLT: rsp_o.data <= glim_o.volt;
                  asg_pkg::ADDR_GLIM_CURR: rsp_o.data <= glim_o.curr;
                  asg_pkg::ADDR_GLIM_PWR: rsp_o.data <= glim_o.pwr;
                  asg_pkg::ADDR_FIRST_PT: rsp_o.data <= first_ff;
                  asg_pkg::ADDR_LAST_PT: rsp_o.data <= last_ff;
                  asg_pkg::ADDR_CYCLES: rsp_o.data <= cycles_ff;
                  asg_pkg::ADDR_RUN_COIL:
                     rsp_o.data <= gen_active_o ? asg_pkg::COIL_READ_ON : '0;
                  asg_pkg::ADDR_VSEL_COIL:
                     rsp_o.data <= tgt_volt_o ? asg_pkg::COIL_READ_ON : '0;
                  asg_pkg::ADDR_CSEL_COIL:
                     rsp_o.data <= tgt_curr_o ? asg_pkg::COIL_READ_ON : '0;
                  default: rsp_o.data <= '0;
               endcase
            end
         end
      end
   end

   // Float microseconds to whole microseconds, saturating
   function automatic logic [31:0] f2u(input logic [31:0] f);
      logic [55:0] tmp;
      logic [7:0] sh;
      tmp = {32'h0, 1'b1, f[22:0]};
      sh = f[30:23] - asg_pkg::FP_EXP_BIAS;
      if (f[31] || f[30:23] < asg_pkg::FP_EXP_BIAS)
         f2u = '0;
      else if (f[30:23] > asg_pkg::FP_EXP_MAX)
         f2u = '1;
      else
      begin
         tmp = tmp << sh[4:0];
         f2u = tmp[54:23];
      end
   endfunction

   asg_tick_div #(
      .DIV(TICK_DIV)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .en_i(state_ff == SQ_RUN),
      .tick_o(tick)
   );

   logic at_last;
   logic last_cycle;
   assign at_last = {9'h0, cur_pt_ff} + 16'h0001 == last_ff;
   assign last_cycle = cycles_ff != asg_pkg::CYCLES_INFINITE && cyc_left_ff <= 16'h0001;

   // Sequencer
   always_ff @(posedge core_clk_i)
   begin
      point_strobe_o <= 1'b0;
      run_done_o <= 1'b0;
      dc_on_req_o <= 1'b0;
      if (reset_i)
      begin
         state_ff <= SQ_IDLE;
         gen_active_o <= 1'b0;
         static_mode_o <= 1'b1;
         cur_pt_ff <= '0;
         cyc_left_ff <= '0;
         rem_us_ff <= '0;
         point_o <= '0;
      end
      else if (do_stop || do_exit)
      begin
         state_ff <= SQ_IDLE;
         gen_active_o <= 1'b0;
         static_mode_o <= 1'b1;
      end
      else
      begin
         case (state_ff)
            SQ_IDLE:
               if (do_start)
               begin
                  state_ff <= SQ_LOAD;
                  gen_active_o <= 1'b1;
                  static_mode_o <= 1'b0;
                  dc_on_req_o <= !dc_on_i;
                  cur_pt_ff <= 7'(first_ff - 16'h0001);
                  cyc_left_ff <= cycles_ff;
               end
            SQ_LOAD:
            begin
               for (int i = 0; i < asg_pkg::VALS_PER_POINT; i++)
                  point_o[i] <= loaded_ff[cur_pt_ff] ? mem[{cur_pt_ff, 3'(i)}] : '0;
               rem_us_ff <= loaded_ff[cur_pt_ff] ?
                  f2u(mem[{cur_pt_ff, asg_pkg::IDX_DURATION}]) : '0;
               point_strobe_o <= 1'b1;
               state_ff <= SQ_RUN;
            end
            SQ_RUN:
               if (rem_us_ff == '0)
               begin
                  state_ff <= SQ_LOAD;
                  if (!at_last)
                     cur_pt_ff <= cur_pt_ff + 7'h01;
                  else if (!last_cycle)
                  begin
                     cur_pt_ff <= 7'(first_ff - 16'h0001);
                     cyc_left_ff <= cyc_left_ff - 16'h0001;
                  end
                  else
                  begin
                     state_ff <= SQ_IDLE;
                     gen_active_o <= 1'b0;
                     static_mode_o <= 1'b1;
                     run_done_o <= 1'b1;
                  end
               end
               else if (tick)
                  rem_us_ff <= rem_us_ff - 32'h1;
            default: state_ff <= SQ_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   chk_tbl_unselected: assert property (req_i.valid && is_wr && is_tbl && !sel_any
      |=> rsp_o.valid && rsp_o.exc) else $error("table write taken without target");
   chk_bad_value: assert property (req_i.valid && is_wr && is_tbl && off[0] && !val_ok
      |=> rsp_o.exc && $stable(loaded_ff)) else $error("invalid value accepted");
   chk_run_unselected: assert property (!sel_any && state_ff == SQ_IDLE
      |=> !gen_active_o) else $error("run without target");
   chk_answer_next: assert property (req_i.valid |=> rsp_o.valid ##1 !$past(req_i.valid)
      || rsp_o.valid) else $error("missing answer");
   chk_exit_wipe: assert property (do_exit
      |=> loaded_ff == '0 && !tgt_volt_o && !tgt_curr_o && !gen_active_o)
      else $error("settings survive exit");
   chk_inf_loop: assert property (state_ff == SQ_RUN && rem_us_ff == '0 && at_last &&
      cycles_ff == asg_pkg::CYCLES_INFINITE && !do_stop && !do_exit
      |=> state_ff == SQ_LOAD ##1 point_strobe_o) else $error("infinite run ended");
   chk_finite_end: assert property (run_done_o
      |-> !gen_active_o && static_mode_o && !dc_on_req_o) else $error("bad run end");
   chk_static_idle: assert property (state_ff == SQ_IDLE |-> static_mode_o && !gen_active_o)
      else $error("generator active while idle");
   chk_auto_dc_on: assert property (do_start && state_ff == SQ_IDLE && !dc_on_i
      |=> dc_on_req_o ##1 !dc_on_req_o) else $error("terminals not switched on");
   chk_point_order: assert property (point_strobe_o
      |-> {9'h0, cur_pt_ff} >= first_ff - 16'h0001 && {9'h0, cur_pt_ff} < last_ff)
      else $error("point outside block");
endmodule
`default_nettype wire

// ### sim/asg_host_model.sv
// Behavioural remote host issuing decoded register and coil accesses
`timescale 1ns/1ns
`default_nettype none
module asg_host_model (
   input wire logic core_clk_i,     // System clock
   output asg_pkg::asg_req_t req_o  // Access to the block
);
   initial req_o = '0;
   // One word per edge; back-to-back words form one multiple write
   task automatic send(input asg_pkg::asg_op_t op, input logic [15:0] addr,
      input logic [15:0] data);
      @(negedge core_clk_i);
      req_o <= '{valid: 1'b1, op: op, addr: addr, data: data};
   endtask
   // Released lines toggle so a stale word cannot pass for a fresh one
   task automatic idle();
      @(negedge core_clk_i);
      req_o <= '{valid: 1'b0, op: asg_pkg::ASG_OP_READ, addr: ~req_o.addr, data: ~req_o.data};
   endtask
   // Whole point as sixteen ascending words, upper half first
   task automatic load_point(input int seq, input asg_pkg::asg_point_t pt);
      for (int i = 0; i < 16; i++)
      begin
         send(asg_pkg::ASG_OP_WR_MULTI, asg_pkg::ADDR_TABLE + 16'(16 * (seq - 1) + i),
            i[0] ? pt[i / 2][15:0] : pt[i / 2][31:16]);
      end
   endtask
endmodule
`default_nettype wire

// ### sim/asg_ctrl_tb.sv
// Self-checking bench of the arbitrary sequence generator control
`timescale 1ns/1ns
`default_nettype none
module asg_ctrl_tb;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic dc_on_i = 1'b0;
   asg_pkg::asg_req_t req;
   asg_pkg::asg_rsp_t rsp;
   asg_pkg::asg_adj_t adj = '{volt: 32'h42C80000, curr: 32'h41200000};
   asg_pkg::asg_point_t point, pt1, pt2, pt3;
   asg_pkg::asg_glim_t glim;
   logic strobe, active, stat, tv, tc, dcreq, done;
   int errors = 0;
   int comparisons = 0;
   int strobes = 0;
   int dcreqs = 0;
   int dones = 0;
   logic [17:0] rsp_q[$];
   asg_pkg::asg_point_t pt_q[$];
   logic [15:0] lim;
   always #5 core_clk_i = ~core_clk_i;
   asg_host_model host (.core_clk_i(core_clk_i), .req_o(req));
   asg_ctrl #(.TICK_DIV(4)) dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req),
      .rsp_o(rsp), .adj_i(adj), .dc_on_i(dc_on_i), .point_o(point), .point_strobe_o(strobe),
      .gen_active_o(active), .static_mode_o(stat), .tgt_volt_o(tv), .tgt_curr_o(tc),
      .glim_o(glim), .dc_on_req_o(dcreq), .run_done_o(done));
   task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Read data is only defined for reads, so writes compare the refusal flag alone
   task automatic acc(input asg_pkg::asg_op_t op, input logic [15:0] addr,
      input logic [15:0] data, input logic [16:0] exp);
      rsp_q.push_back({op == asg_pkg::ASG_OP_READ, exp});
      host.send(op, addr, data);
   endtask
   task automatic load(input int seq, input asg_pkg::asg_point_t pt, input int bad);
      for (int i = 0; i < 16; i++)
      begin
         rsp_q.push_back({1'b0, i == 2 * bad + 1, 16'h0000});
      end
      host.load_point(seq, pt);
   endtask
   task automatic wait_cnt(input bit which, input int n);
      for (int i = 0; i < 600; i++)
      begin
         @(negedge core_clk_i);
         if ((which ? dones : strobes) >= n)
            return;
      end
      check("wait bound", 1, 0);
      finish_test();
   endtask
   always @(posedge core_clk_i)
   begin
      if (!reset_i && rsp.valid === 1'b1)
      begin
         if (rsp_q.size() == 0)
            check("unexpected answer", 1, 0);
         else
         begin
            logic [17:0] e;
            e = rsp_q.pop_front();
            check("refusal flag", rsp.exc, e[16]);
            if (e[17])
               check("read data", rsp.data, e[15:0]);
         end
      end
      if (!reset_i && strobe === 1'b1)
      begin
         strobes++;
         if (pt_q.size() == 0)
            check("unexpected point", 1, 0);
         else
            check("point values", point, pt_q.pop_front());
      end
      if (dcreq === 1'b1)
         dcreqs++;
      if (done === 1'b1)
         dones++;
   end
   // Terminals follow the switch-on request
   always @(negedge core_clk_i)
      if (dcreq === 1'b1)
         dc_on_i <= 1'b1;
   initial
   begin
      void'($urandom(22344));
      pt1 = '0;
      pt1[4] = $urandom() & 32'h3FFFFFFF;
      pt1[6] = 32'h42480000;
      pt1[7] = 32'h40400000;
      pt2 = '0;
      pt2[5] = 32'h42480000;
      pt2[6] = 32'h42480000;
      pt2[7] = 32'h40000000;
      pt3 = pt2;
      pt3[6] = 32'h43480000;
      lim = 16'($urandom());
      repeat (10) @(negedge core_clk_i);
      reset_i = 1'b0;
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_RUN_COIL, asg_pkg::COIL_ON, 17'h10000);
      acc(asg_pkg::ASG_OP_WR_MULTI, asg_pkg::ADDR_TABLE, 16'h0000, 17'h10000);
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_VSEL_COIL, 16'h1234, 17'h10000);
      acc(asg_pkg::ASG_OP_READ, 16'h0100, 16'h0000, 17'h00000);
      acc(asg_pkg::ASG_OP_WR_SINGLE, 16'h0100, 16'h0005, 17'h10000);
      acc(asg_pkg::ASG_OP_READ, asg_pkg::ADDR_GLIM_PWR, 16'h0000, {1'b0, 16'hCCCC});
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_VSEL_COIL, asg_pkg::COIL_ON, 17'h00000);
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_CSEL_COIL, asg_pkg::COIL_ON, 17'h10000);
      acc(asg_pkg::ASG_OP_READ, asg_pkg::ADDR_VSEL_COIL, 16'h0000, 17'h00001);
      acc(asg_pkg::ASG_OP_WR_SINGLE, asg_pkg::ADDR_FIRST_PT, 16'h0001, 17'h00000);
      acc(asg_pkg::ASG_OP_WR_SINGLE, asg_pkg::ADDR_LAST_PT, 16'h0002, 17'h00000);
      acc(asg_pkg::ASG_OP_WR_SINGLE, asg_pkg::ADDR_CYCLES, 16'h0001, 17'h00000);
      acc(asg_pkg::ASG_OP_READ, asg_pkg::ADDR_LAST_PT, 16'h0000, 17'h00002);
      acc(asg_pkg::ASG_OP_WR_SINGLE, asg_pkg::ADDR_GLIM_CURR, lim, 17'h00000);
      acc(asg_pkg::ASG_OP_READ, asg_pkg::ADDR_GLIM_CURR, 16'h0000, {1'b0, lim});
      load(1, pt1, -1);
      load(2, pt2, -1);
      load(3, pt3, 6);
      host.idle();
      @(negedge core_clk_i);
      check("voltage target", {tv, tc}, 2'b10);
      check("current limit", glim.curr, lim);
      check("all limits", glim, {asg_pkg::LIMIT_FULL_SCALE, lim, asg_pkg::LIMIT_FULL_SCALE});
      check("static before run", {active, stat}, 2'b01);
      pt_q.push_back(pt1);
      pt_q.push_back(pt2);
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_RUN_COIL, asg_pkg::COIL_ON, 17'h00000);
      host.idle();
      @(negedge core_clk_i);
      check("running", {active, stat}, 2'b10);
      wait_cnt(1'b1, 1);
      check("after finite run", {active, stat, dc_on_i}, 3'b011);
      check("points run", strobes, 2);
      check("switch-on requests", dcreqs, 1);
      acc(asg_pkg::ASG_OP_WR_SINGLE, asg_pkg::ADDR_CYCLES, asg_pkg::CYCLES_INFINITE, 17'h00000);
      pt_q.push_back(pt1);
      pt_q.push_back(pt2);
      pt_q.push_back(pt1);
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_RUN_COIL, asg_pkg::COIL_ON, 17'h00000);
      host.idle();
      wait_cnt(1'b0, 5);
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_RUN_COIL, asg_pkg::COIL_OFF, 17'h00000);
      host.idle();
      repeat (2) @(negedge core_clk_i);
      check("stopped", {active, stat}, 2'b01);
      check("endless run end", {dones, dcreqs}, {32'd1, 32'd1});
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_VSEL_COIL, asg_pkg::COIL_OFF, 17'h00000);
      acc(asg_pkg::ASG_OP_READ, asg_pkg::ADDR_FIRST_PT, 16'h0000, 17'h00000);
      acc(asg_pkg::ASG_OP_READ, asg_pkg::ADDR_GLIM_CURR, 16'h0000, {1'b0, 16'hCCCC});
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_RUN_COIL, asg_pkg::COIL_ON, 17'h10000);
      // Current target checks against the lower current limit
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_CSEL_COIL, asg_pkg::COIL_ON, 17'h00000);
      acc(asg_pkg::ASG_OP_WR_MULTI, asg_pkg::ADDR_TABLE + 16'h000A, 16'h4248, 17'h00000);
      acc(asg_pkg::ASG_OP_WR_MULTI, asg_pkg::ADDR_TABLE + 16'h000B, 16'h0000, 17'h10000);
      acc(asg_pkg::ASG_OP_WR_COIL, asg_pkg::ADDR_CSEL_COIL, asg_pkg::COIL_OFF, 17'h00000);
      host.idle();
      repeat (3) @(negedge core_clk_i);
      check("target released", {tv, tc}, 2'b00);
      check("answers left", rsp_q.size(), 0);
      finish_test();
   end
endmodule
`default_nettype wire
